/* verilog/prm_register_map.sv */
/*
  Peripheral register map: 256 byte registers behind an AXI4-Lite slave,
  with reset-source dependent reset values and a switched serial/I2C window.
  Assumes the reset controller drives the cause and option inputs from
  logic on mclk, stable while reset_n is low.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`default_nettype none
module prm_register_map
  import prm_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Reset cause and option bits
  input  wire logic                  retainReset,
  input  wire logic                  powerOnReset,
  input  wire logic                  lowVoltageOption,
  input  wire logic                  countProtectOption,
  input  wire logic [7:0]            factoryTrim,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output var  logic [1:0]            s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // AXI4-Lite read data
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  // Window selection
  output var  logic                  i2cSelected
);
  logic [7:0] regFile [ENTRIES];
  logic [7:0] i2cBank [I2C_BANK_SIZE];

  logic       awHeld;
  logic       wHeld;
  logic [7:0] wrIndex;
  logic [7:0] wrByte;
  logic       wrLaneOn;
  logic       wrFire;
  logic       wrMapped;
  logic       wrToWindow;
  logic [3:0] wrSlot;
  logic [7:0] rdIndex;
  logic       rdToWindow;
  logic [3:0] rdSlot;
  logic [7:0] rdByte;
  logic       selI2c;
  logic       next_awHeld;
  logic       next_wHeld;
  logic       next_bvalid;
  logic       next_rvalid;

  assign selI2c = regFile[IDX_PORT_MODE][I2C_SEL_BIT];

  function automatic logic in_window(input logic [7:0] idx);
    return (idx >= IDX_WIN_FIRST && idx <= IDX_WIN_LAST) || idx == IDX_SHARED_IRQ;
  endfunction

  function automatic logic [3:0] window_slot(input logic [7:0] idx);
    return (idx == IDX_SHARED_IRQ) ? I2C_IRQ_SLOT : {1'b0, idx[2:0]};
  endfunction

  // Write path: address and data taken in either order
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld  <= 1'b0;
      wrIndex <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld  <= 1'b1;
      wrIndex <= s_axi_awaddr[9:2];
    end else if (wrFire) begin
      awHeld  <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wHeld    <= 1'b0;
      wrByte   <= 8'h00;
      wrLaneOn <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld    <= 1'b1;
      wrByte   <= s_axi_wdata[7:0];
      wrLaneOn <= s_axi_wstrb[0];
    end else if (wrFire) begin
      wHeld    <= 1'b0;
    end
  end

  assign wrFire        = awHeld && wHeld;

  // Ready flags registered from the next-cycle held and busy state
  assign next_awHeld = (s_axi_awvalid && s_axi_awready) || (awHeld && !wrFire);
  assign next_wHeld  = (s_axi_wvalid && s_axi_wready) || (wHeld && !wrFire);
  assign next_bvalid = wrFire || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !next_awHeld && !next_bvalid;
      s_axi_wready  <= !next_wHeld && !next_bvalid;
      s_axi_arready <= !next_rvalid;
    end
  end
  assign wrMapped      = prm_is_mapped(wrIndex);
  assign wrToWindow    = in_window(wrIndex) && selI2c;
  assign wrSlot        = window_slot(wrIndex);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register entries: masked reload on reset, byte write otherwise
  for (genvar gi = 0; gi < ENTRIES; gi++) begin : gEntry
    localparam logic [7:0] IDX = 8'(gi);
    logic [7:0] rstMask;
    logic [7:0] rstValue;
    assign rstMask  = prm_reset_mask(IDX, retainReset);
    assign rstValue = prm_reset_value(IDX, powerOnReset, lowVoltageOption,
                                      countProtectOption, factoryTrim);
    always_ff @(posedge mclk) begin
      if (!reset_n)
        regFile[gi] <= (regFile[gi] & ~rstMask) | (rstValue & rstMask);
      else if (wrFire && wrLaneOn && wrMapped && !wrToWindow && wrIndex == IDX)
        regFile[gi] <= wrByte;
    end
  end

  // Second bank of the window, seen while the I2C unit is selected
  for (genvar gj = 0; gj < I2C_BANK_SIZE; gj++) begin : gI2c
    localparam logic [7:0] IDX = (gj == I2C_BANK_SIZE - 1) ? IDX_SHARED_IRQ : 8'(IDX_WIN_FIRST + gj);
    logic [7:0] rstMask;
    assign rstMask = (IDX == IDX_WIN_STATUS) ? MASK_BIT3_UNDEF : prm_reset_mask(IDX, 1'b0);
    always_ff @(posedge mclk) begin
      if (!reset_n)
        i2cBank[gj] <= (i2cBank[gj] & ~rstMask) | (prm_reset_value(IDX, 1'b0, 1'b0, 1'b1, 8'h00) & rstMask);
      else if (wrFire && wrLaneOn && wrToWindow && wrSlot == 4'(gj))
        i2cBank[gj] <= wrByte;
    end
  end

  // Read path: one cycle from address to data
  assign rdIndex       = s_axi_araddr[9:2];
  assign rdToWindow    = in_window(rdIndex) && selI2c;
  assign rdSlot        = window_slot(rdIndex);

  always_comb begin
    rdByte = 8'h00;
    if (prm_is_mapped(rdIndex))
      rdByte = rdToWindow ? i2cBank[rdSlot] : regFile[rdIndex];
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rdByte};
      s_axi_rresp  <= prm_is_mapped(rdIndex) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      i2cSelected <= 1'b0;
    else
      i2cSelected <= selI2c;
  end
endmodule // prm_register_map
`default_nettype wire

/* verilog/prm_pkg.sv */
/*
  Constants of the peripheral register map: byte indices, reset masks,
  reset values and the address decode.
  Assumes byte index = AXI byte address / 4, one byte per 32-bit word.
*/
`default_nettype none
package prm_pkg;
  localparam int          AXI_ADDR_W = 10;
  localparam int          ENTRIES    = 256;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam logic [7:0] IDX_PROC_MODE_0   = 8'h04;
  localparam logic [7:0] IDX_PROC_MODE_1   = 8'h05;
  localparam logic [7:0] IDX_SYS_CLK_0     = 8'h06;
  localparam logic [7:0] IDX_SYS_CLK_1     = 8'h07;
  localparam logic [7:0] IDX_WRITE_PROTECT = 8'h0A;
  localparam logic [7:0] IDX_OSC_STOP      = 8'h0C;
  localparam logic [7:0] IDX_WDOG_REFRESH  = 8'h0D;
  localparam logic [7:0] IDX_WDOG_START    = 8'h0E;
  localparam logic [7:0] IDX_WDOG_CONTROL  = 8'h0F;
  localparam logic [7:0] IDX_ADDR_MATCH_0  = 8'h10;
  localparam logic [7:0] IDX_ADDR_MATCH_EN = 8'h13;
  localparam logic [7:0] IDX_ADDR_MATCH_1  = 8'h14;
  localparam logic [7:0] IDX_COUNT_PROTECT = 8'h1C;
  localparam logic [7:0] IDX_FAST_OSC_0    = 8'h23;
  localparam logic [7:0] IDX_FAST_OSC_TRIM = 8'h24;
  localparam logic [7:0] IDX_FAST_OSC_2    = 8'h25;
  localparam logic [7:0] IDX_VOLT_DETECT_1 = 8'h31;
  localparam logic [7:0] IDX_VOLT_DETECT_2 = 8'h32;
  localparam logic [7:0] IDX_SUPPLY_MON_1  = 8'h36;
  localparam logic [7:0] IDX_SUPPLY_MON_2  = 8'h37;
  localparam logic [7:0] IDX_SHARED_IRQ    = 8'h4F;
  localparam logic [7:0] IDX_UART_A_BASE   = 8'hA0;
  localparam logic [7:0] IDX_UART_B_BASE   = 8'hA8;
  localparam logic [7:0] IDX_WIN_FIRST     = 8'hB8;
  localparam logic [7:0] IDX_WIN_LAST      = 8'hBF;
  localparam logic [7:0] IDX_WIN_CTRL_LOW  = 8'hB9;
  localparam logic [7:0] IDX_WIN_MODE      = 8'hBA;
  localparam logic [7:0] IDX_WIN_STATUS    = 8'hBC;
  localparam logic [7:0] IDX_WIN_TX_DATA   = 8'hBE;
  localparam logic [7:0] IDX_WIN_RX_DATA   = 8'hBF;
  localparam logic [7:0] IDX_PORT_MODE     = 8'hF8;
  localparam logic [7:0] IDX_PULL_UP_1     = 8'hFD;
  localparam int         I2C_SEL_BIT       = 7;
  localparam int         I2C_BANK_SIZE     = 9;
  localparam logic [3:0] I2C_IRQ_SLOT      = 4'h8;

  localparam logic [7:0] RV_SYS_CLK_0    = 8'h68;
  localparam logic [7:0] RV_SYS_CLK_1    = 8'h20;
  localparam logic [7:0] RV_OSC_STOP     = 8'h04;
  localparam logic [7:0] RV_WDOG_CONTROL = 8'h1F;
  localparam logic [7:0] RV_COUNT_PROT   = 8'h80;
  localparam logic [7:0] RV_VOLT_DET_1   = 8'h08;
  localparam logic [7:0] RV_VOLT_DET_2   = 8'h40;
  localparam logic [7:0] RV_SUPPLY_MON_1 = 8'h41;
  localparam logic [7:0] RV_UART_CTRL_0  = 8'h08;
  localparam logic [7:0] RV_UART_CTRL_1  = 8'h02;
  localparam logic [7:0] RV_WIN_CTRL_LOW = 8'h7D;
  localparam logic [7:0] RV_WIN_MODE     = 8'h18;
  localparam logic [7:0] RV_WIN_DATA     = 8'hFF;
  localparam logic [7:0] RV_ZERO         = 8'h00;

  localparam logic [7:0] MASK_ALL        = 8'hFF;
  localparam logic [7:0] MASK_NONE       = 8'h00;
  localparam logic [7:0] MASK_WDOG_CTRL  = 8'hDF;
  localparam logic [7:0] MASK_IRQ        = 8'h07;
  localparam logic [7:0] MASK_EXT_IRQ    = 8'h37;
  localparam logic [7:0] MASK_PULL_UP_1  = 8'h33;
  localparam logic [7:0] MASK_BIT3_UNDEF = 8'hF7;
  localparam logic [7:0] KEEP_VOLT_DET_2 = 8'h80;
  localparam logic [7:0] KEEP_SUPPLY_M1  = 8'hBE;
  localparam logic [7:0] KEEP_SUPPLY_M2  = 8'h0C;

  function automatic logic prm_is_mapped(input logic [7:0] idx);
    unique case (idx)
      8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1C,
      8'h23, 8'h24, 8'h25, 8'h31, 8'h32, 8'h36, 8'h37,
      8'h48, 8'h49, 8'h4A, 8'h4D, 8'h4E, 8'h4F, 8'h51, 8'h52, 8'h53, 8'h54,
      8'h55, 8'h56, 8'h58, 8'h59, 8'h5A, 8'h5D,
      8'hC0, 8'hC1, 8'hD4, 8'hD6, 8'hD7,
      8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hEA,
      8'hEC, 8'hEE, 8'hF5, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD:
        return 1'b1;
      default:
        return (idx >= IDX_UART_A_BASE && idx <= IDX_WIN_LAST && idx != 8'hB0
                && !(idx > 8'hB0 && idx < IDX_WIN_FIRST));
    endcase
  endfunction

  // Bits loaded by a reset; retain selects the partial reset sources
  function automatic logic [7:0] prm_reset_mask(input logic [7:0] idx, input logic retain);
    unique case (idx)
      IDX_VOLT_DETECT_1: return retain ? MASK_NONE : MASK_ALL;
      IDX_VOLT_DETECT_2: return retain ? ~KEEP_VOLT_DET_2 : MASK_ALL;
      IDX_SUPPLY_MON_1:  return retain ? ~KEEP_SUPPLY_M1 : MASK_BIT3_UNDEF;
      IDX_SUPPLY_MON_2:  return retain ? ~KEEP_SUPPLY_M2 : MASK_ALL;
      IDX_WDOG_CONTROL:  return MASK_WDOG_CTRL;
      IDX_WDOG_REFRESH, IDX_WDOG_START, 8'hA1, 8'hA2, 8'hA3, 8'hA6, 8'hA7,
      8'hA9, 8'hAA, 8'hAB, 8'hAE, 8'hAF, 8'hC0, 8'hC1,
      8'hE0, 8'hE1, 8'hE4, 8'hE5, 8'hE8, 8'hEC, 8'hF5: return MASK_NONE;
      8'h55, 8'h59, 8'h5A, 8'h5D: return MASK_EXT_IRQ;
      IDX_PULL_UP_1:     return MASK_PULL_UP_1;
      default: begin
        if (idx >= 8'h48 && idx <= 8'h5D)
          return MASK_IRQ;
        return prm_is_mapped(idx) ? MASK_ALL : MASK_NONE;
      end
    endcase
  endfunction

  function automatic logic [7:0] prm_reset_value(input logic [7:0] idx, input logic powerOn,
                                                 input logic lowVoltOpt, input logic countProtOpt,
                                                 input logic [7:0] trim);
    unique case (idx)
      IDX_SYS_CLK_0:     return RV_SYS_CLK_0;
      IDX_SYS_CLK_1:     return RV_SYS_CLK_1;
      IDX_OSC_STOP:      return RV_OSC_STOP;
      IDX_WDOG_CONTROL:  return RV_WDOG_CONTROL;
      IDX_COUNT_PROTECT: return countProtOpt ? RV_ZERO : RV_COUNT_PROT;
      IDX_FAST_OSC_TRIM: return trim;
      IDX_VOLT_DETECT_1: return RV_VOLT_DET_1;
      IDX_VOLT_DETECT_2: return (powerOn || !lowVoltOpt) ? RV_VOLT_DET_2 : RV_ZERO;
      IDX_SUPPLY_MON_1:  return (powerOn || !lowVoltOpt) ? RV_SUPPLY_MON_1 : RV_ZERO;
      8'hA4, 8'hAC:      return RV_UART_CTRL_0;
      8'hA5, 8'hAD:      return RV_UART_CTRL_1;
      IDX_WIN_CTRL_LOW:  return RV_WIN_CTRL_LOW;
      IDX_WIN_MODE:      return RV_WIN_MODE;
      IDX_WIN_TX_DATA, IDX_WIN_RX_DATA: return RV_WIN_DATA;
      default:           return RV_ZERO;
    endcase
  endfunction
endpackage
`default_nettype wire

/* tb/prm_register_map_props.sv */
/*
  Bus and window checks on the register map's ports.
  Assumes a bind onto prm_register_map; one clock, mclk.
*/
`default_nettype none
module prm_register_map_props
  import prm_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  reset_n,
  // Write channels
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [1:0]            s_axi_bresp,
  // Read channels
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  // Window
  input wire logic                  i2cSelected
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire awTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire selWritten = s_axi_wdata[I2C_SEL_BIT];

  property p_write_answer;
    awTake |=> ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response not on time");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data not on time");
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped early");
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_stands: assert property (p_r_stands)
    else $error("read data dropped early");
  property p_byte_wide;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("upper read bytes not zero");
  property p_gap_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_gap_zero: assert property (p_gap_zero)
    else $error("unmapped read data not zero");
  property p_write_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("write accepted during response");
  property p_read_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_read_busy: assert property (p_read_busy)
    else $error("read accepted during response");
  property p_window_select;
    awTake && s_axi_awaddr[AXI_ADDR_W-1:2] == IDX_PORT_MODE |-> ##3 i2cSelected == $past(selWritten, 3);
  endproperty
  a_window_select: assert property (p_window_select)
    else $error("window select not following port mode");

  c_write: cover property (awTake);
  c_gap: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_i2c: cover property ($rose(i2cSelected));
endmodule // prm_register_map_props

bind prm_register_map prm_register_map_props u_props (.*);
`default_nettype wire

/* tb/prm_cpu_model.sv */
/*
  CPU side bus master: one byte access at a time over AXI4-Lite.
  Assumes callers enter its tasks just after a rising mclk edge.
*/
`default_nettype none
module prm_cpu_model
  import prm_pkg::*;
(
  // Clock
  input  wire logic                  mclk,
  // Write channels
  output var  logic                  s_axi_awvalid,
  input  wire logic                  s_axi_awready,
  output var  logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  output var  logic                  s_axi_wvalid,
  input  wire logic                  s_axi_wready,
  output var  logic [31:0]           s_axi_wdata,
  output var  logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_bvalid,
  output var  logic                  s_axi_bready,
  input  wire logic [1:0]            s_axi_bresp,
  // Read channels
  output var  logic                  s_axi_arvalid,
  input  wire logic                  s_axi_arready,
  output var  logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_rvalid,
  output var  logic                  s_axi_rready,
  input  wire logic [31:0]           s_axi_rdata,
  input  wire logic [1:0]            s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_wstrb, s_axi_bready,
           s_axi_arvalid, s_axi_araddr, s_axi_rready} = '0;

  // Slow delays the response ready by that many cycles
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s,
                    input int slow, output logic [1:0] resp);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin @(posedge mclk iff s_axi_awready); s_axi_awvalid <= 1'h0; end
      begin @(posedge mclk iff s_axi_wready); s_axi_wvalid <= 1'h0; end
    join
    repeat (slow) @(posedge mclk);
    s_axi_bready <= 1'h1;
    @(posedge mclk iff s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] i, input int slow, output logic [7:0] d, output logic [1:0] resp);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    @(posedge mclk iff s_axi_arready);
    s_axi_arvalid <= 1'h0;
    repeat (slow) @(posedge mclk);
    s_axi_rready <= 1'h1;
    @(posedge mclk iff s_axi_rvalid);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
endmodule // prm_cpu_model
`default_nettype wire

/* tb/prm_register_map_test.sv */
/*
  Self-checking bench: reset values per cause, retention, window, gaps.
  Assumes prm_cpu_model as master and the bound props checker.
*/
`default_nettype none
module prm_register_map_test
  import prm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, reset_n = 1'h0, retainReset = 1'h0, powerOnReset = 1'h1;
  logic lowVoltageOption = 1'h0, countProtectOption = 1'h1;
  logic [7:0] factoryTrim = 8'h08;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, i2cSelected;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  integer seed = 32'h3216;
  int mismatches = 0, cmp_count = 0;
  localparam logic [7:0] REGS [37] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0C, 8'h0F, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h14, 8'h16, 8'h1C, 8'h23, 8'h24, 8'h25, 8'h31, 8'h32, 8'h36, 8'h37, 8'h48, 8'h4F,
    8'h55, 8'hA0, 8'hA4, 8'hA5, 8'hAC, 8'hAD, 8'hB9, 8'hBA, 8'hBC, 8'hBE, 8'hBF, 8'hE2, 8'hFC, 8'hFD};
  localparam logic [7:0] GAPS [5] = '{8'h00, 8'h0B, 8'h40, 8'hB0, 8'hFF};
  logic [7:0] prev [37];

  always #10 mclk = ~mclk;
  prm_register_map u_dut (.*);
  prm_cpu_model u_cpu (.*);

  // Reset value as {loaded bits, value}
  function automatic logic [15:0] rv(input logic [7:0] i);
    logic lv;
    lv = powerOnReset || !lowVoltageOption;
    case (i)
      8'h06: return 16'hFF68;
      8'h07: return 16'hFF20;
      8'h0C: return 16'hFF04;
      8'h0F: return 16'hDF1F;
      8'h1C: return {8'hFF, countProtectOption ? 8'h00 : 8'h80};
      8'h24: return {8'hFF, factoryTrim};
      8'h31: return 16'hFF08;
      8'h32: return {8'hFF, lv ? 8'h40 : 8'h00};
      8'h36: return {8'hF7, lv ? 8'h41 : 8'h00};
      8'h48, 8'h4F: return 16'h0700;
      8'h55: return 16'h3700;
      8'hA4, 8'hAC: return 16'hFF08;
      8'hA5, 8'hAD: return 16'hFF02;
      8'hB9: return 16'hFF7D;
      8'hBA: return 16'hFF18;
      8'hBE, 8'hBF: return 16'hFFFF;
      8'hFD: return 16'h3300;
      default: return 16'hFF00;
    endcase
  endfunction

  function automatic logic [7:0] kept(input logic [7:0] i);
    case (i)
      8'h31: return 8'hFF;
      8'h32: return 8'h80;
      8'h36: return 8'hBE;
      8'h37: return 8'h0C;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] i, input logic [7:0] e, input logic [7:0] g,
                     input logic [7:0] m);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("unexpected %s at %h: expected %h seen %h", nm, i, e & m, g & m);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_cpu.wr(i, d, 4'h1, $unsigned($random(seed)) % 3, r);
    chk("bresp", i, {6'h0, er}, {6'h0, r}, 8'hFF);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m, input logic [1:0] er);
    logic [7:0] d;
    logic [1:0] r;
    u_cpu.rd(i, $unsigned($random(seed)) % 3, d, r);
    chk("rresp", i, {6'h0, er}, {6'h0, r}, 8'hFF);
    chk("rdata", i, e, d, m);
  endtask

  task automatic rst(input logic ret, input logic por, input logic [7:0] t);
    retainReset <= ret;
    powerOnReset <= por;
    lowVoltageOption <= 1'($random(seed));
    countProtectOption <= 1'($random(seed));
    factoryTrim <= t;
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
  endtask

  task automatic finish_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    finish_test();
  end

  initial begin
    logic [15:0] e;
    logic [7:0] k;
    logic [1:0] r;
    repeat (20) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    for (int n = 0; n < 6; n++) begin
      // Odd rounds are partial resets over the previous round's data
      if (n > 0)
        rst(1'(n % 2), n % 2 == 0 && 1'($random(seed)),
            n == 2 ? 8'hF7 : 8'h08 + 8'($unsigned($random(seed)) % 240));
      foreach (REGS[j]) begin
        e = rv(REGS[j]);
        k = retainReset ? kept(REGS[j]) : 8'h00;
        rd(REGS[j], (prev[j] & k) | (e[7:0] & ~k), e[15:8] | k, RESP_OKAY);
      end
      foreach (REGS[j]) begin
        prev[j] = 8'($random(seed));
        wr(REGS[j], prev[j], RESP_OKAY);
        rd(REGS[j], prev[j], 8'hFF, RESP_OKAY);
      end
    end
    wr(IDX_WIN_CTRL_LOW, 8'hA5, RESP_OKAY);
    wr(IDX_PORT_MODE, 8'h80, RESP_OKAY);
    repeat (2) @(posedge mclk);
    #1;
    chk("i2cSelected", IDX_PORT_MODE, 8'h01, {7'h0, i2cSelected}, 8'hFF);
    @(posedge mclk);
    rd(IDX_WIN_CTRL_LOW, RV_WIN_CTRL_LOW, 8'hFF, RESP_OKAY);
    rd(IDX_WIN_STATUS, 8'h00, 8'hF7, RESP_OKAY);
    rd(IDX_SHARED_IRQ, 8'h00, 8'h07, RESP_OKAY);
    wr(IDX_WIN_CTRL_LOW, 8'h3C, RESP_OKAY);
    wr(IDX_PORT_MODE, 8'h00, RESP_OKAY);
    rd(IDX_WIN_CTRL_LOW, 8'hA5, 8'hFF, RESP_OKAY);
    wr(IDX_PORT_MODE, 8'h80, RESP_OKAY);
    rd(IDX_WIN_CTRL_LOW, 8'h3C, 8'hFF, RESP_OKAY);
    foreach (GAPS[i]) begin
      wr(GAPS[i], 8'h5A, RESP_SLVERR);
      rd(GAPS[i], 8'h00, 8'hFF, RESP_SLVERR);
    end
    wr(IDX_PROC_MODE_0, 8'h11, RESP_OKAY);
    u_cpu.wr(IDX_PROC_MODE_0, 8'hEE, 4'h0, 1, r);
    chk("bresp", IDX_PROC_MODE_0, {6'h0, RESP_OKAY}, {6'h0, r}, 8'hFF);
    rd(IDX_PROC_MODE_0, 8'h11, 8'hFF, RESP_OKAY);
    finish_test();
  end
endmodule // prm_register_map_test
`default_nettype wire
